// >>> timer_event_pkg.sv
package timer_event_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_EV_ROUTING = 8'h0A;
  localparam logic [7:0] IDX_IEN_CLEAR = 8'h0C;
  localparam logic [7:0] IDX_IEN_SET = 8'h0D;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0E;
  localparam logic [7:0] IDX_EV_STATUS = 8'h0F;

  // ************************************************************
  // event routing control fields
  // ************************************************************
  localparam int EV_ACT_LSB = 0;
  localparam int EV_ACT_W = 3;
  localparam int EV_POL_BIT = 4;
  localparam int EV_IN_EN_BIT = 5;
  localparam int WRAP_EO_BIT = 8;
  localparam int CH0_EO_BIT = 12;
  localparam logic [15:0] EV_ROUTING_RST = 16'h0000;
  localparam logic [15:0] EV_ROUTING_MASK = 16'h3137;

  // ************************************************************
  // interrupt enable and flag fields
  // ************************************************************
  localparam int IRQ_WRAP_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_SYNC_BIT = 3;
  localparam int IRQ_CH0_BIT = 4;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [7:0] IRQ_FLAGS_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK = 8'h3B;

  // ************************************************************
  // status fields
  // ************************************************************
  localparam int STAT_EV_LEVEL_BIT = 0;
  localparam int STAT_TIMER_ON_BIT = 1;
  localparam int STAT_GUARD_BIT = 2;

  // event action codes
  typedef enum logic [2:0] {
    ACT_OFF = 3'h0,
    ACT_RETRIGGER = 3'h1,
    ACT_COUNT = 3'h2,
    ACT_START = 3'h3,
    ACT_RSVD4 = 3'h4,
    ACT_PERIOD_REG0 = 3'h5,
    ACT_PERIOD_REG1 = 3'h6,
    ACT_RSVD7 = 3'h7
  } ev_act_t;

  // one-cycle commands toward the counter core
  typedef struct packed {
    logic retrigger;
    logic count;
    logic start;
    logic [1:0] period_cap;
    logic [1:0] width_cap;
  } ev_cmd_t;

  // one-cycle happenings reported by the counter core
  typedef struct packed {
    logic [1:0] ch_hit;
    logic wrap;
    logic cap_collision;
    logic sync_done;
  } core_evt_t;

endpackage

// >>> timer_event_ctrl.sv
`timescale 1ns/1ps
// How it works
// - channel event out follows hit when enabled
// - wrap event out follows wrap when enabled
// - input enable bit gates incoming event
// - polarity bit inverts incoming event source
// - codes 1,2,3 retrigger, count, start
// - code 5: period reg0, width reg1
// - code 6: period reg1, width reg0
// - routing writes ignored while enabled or guarded
// - clear register bits 4,5 drop channel enables
// - clear register bit 1 drops error enable
// - clear register bit 0 drops wrap enable
// - set register bits 4,5 raise channel enables
// - set register bit 1 raises error enable
// - set register bit 0 raises wrap enable
// - set and clear share one enable state
// - clear register bit 3 drops sync enable
// - channel flag rises on match or capture
// - irq when flag set and enable set
module timer_event_ctrl
  import timer_event_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // counter core side
  input wire logic timer_enabled,
  input wire logic write_guard,
  input wire core_evt_t core_evt,
  output ev_cmd_t ev_cmd,
  // event system side
  input wire logic event_in,
  output logic [1:0] channel_event_out,
  output logic wrap_event_out,
  // interrupt controller side
  output logic irq
);

  // ************************************************************
  // reset release
  // ************************************************************

  logic [1:0] rst_sync_q;
  logic rst_n;

  // asynchronous assert, two-flop release
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // ************************************************************
  // helpers
  // ************************************************************

  // byte address of a register index
  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx[5:0], 2'b00};
  endfunction

  // merge write data into a register by byte lane
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [15:0] wd,
                                             input logic [1:0] be);
    logic [15:0] res;
    res = old;
    if (be[0])
      res[7:0] = wd[7:0];
    if (be[1])
      res[15:8] = wd[15:8];
    lane_merge = res;
  endfunction

  // ************************************************************
  // bus handshake
  // ************************************************************

  logic wait_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr_go;
  logic [31:0] rdata_d;

  assign req = read | write;
  // write takes effect on the edge where waitrequest is sampled low
  assign wr_go = write & ~wait_q;

  // one wait cycle, then answer for one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wait_q <= 1'b1;
    else if (req && wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  // ************************************************************
  // event routing control
  // ************************************************************

  logic [15:0] ev_routing_q;
  logic ev_wr;

  // refused while counter runs or guard is up
  assign ev_wr = wr_go && (address == reg_addr(IDX_EV_ROUTING))
                 && !timer_enabled && !write_guard;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ev_routing_q <= EV_ROUTING_RST;
    else if (ev_wr)
      ev_routing_q <= lane_merge(ev_routing_q, writedata[15:0], byteenable[1:0])
                      & EV_ROUTING_MASK;
  end

  // ************************************************************
  // interrupt enables, one state behind set and clear
  // ************************************************************

  logic [7:0] ien_q;
  logic [7:0] ien_d;
  logic ien_clr_wr;
  logic ien_set_wr;

  assign ien_clr_wr = wr_go && (address == reg_addr(IDX_IEN_CLEAR))
                      && byteenable[0] && !write_guard;
  assign ien_set_wr = wr_go && (address == reg_addr(IDX_IEN_SET))
                      && byteenable[0] && !write_guard;

  // ones clear or set, zeros leave bits alone
  always_comb
  begin
    ien_d = ien_q;
    if (ien_clr_wr)
      ien_d = ien_q & ~(writedata[7:0] & IRQ_MASK);
    if (ien_set_wr)
      ien_d = ien_q | (writedata[7:0] & IRQ_MASK);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ien_q <= IEN_RST;
    else
      ien_q <= ien_d;
  end

  // ************************************************************
  // interrupt flags
  // ************************************************************

  logic [7:0] flags_q;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  // hardware happenings mapped onto flag positions
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[IRQ_WRAP_BIT] = core_evt.wrap;
    flag_set[IRQ_ERR_BIT] = core_evt.cap_collision;
    flag_set[IRQ_SYNC_BIT] = core_evt.sync_done;
    flag_set[IRQ_CH0_BIT +: 2] = core_evt.ch_hit;
  end

  assign flag_clr = (wr_go && (address == reg_addr(IDX_IRQ_FLAGS)) && byteenable[0])
                    ? (writedata[7:0] & IRQ_MASK) : 8'h00;

  // a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_q <= IRQ_FLAGS_RST;
    else
      flags_q <= (flags_q & ~flag_clr) | flag_set;
  end

  // request while any enabled flag stands
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(flags_q & ien_q);
  end

  // ************************************************************
  // event outputs
  // ************************************************************

  // one pulse per hit or wrap, gated by enables
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      channel_event_out <= 2'b00;
      wrap_event_out <= 1'b0;
    end
    else
    begin
      channel_event_out <= core_evt.ch_hit & ev_routing_q[CH0_EO_BIT +: 2];
      wrap_event_out <= core_evt.wrap & ev_routing_q[WRAP_EO_BIT];
    end
  end

  // ************************************************************
  // incoming event
  // ************************************************************

  logic ev_meta_q;
  logic ev_sync_q;
  logic ev_level;
  logic ev_last_q;
  logic ev_prev_level;
  logic ev_rise;
  logic ev_fall;

  // pin is asynchronous, two flops before use
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ev_meta_q <= 1'b0;
      ev_sync_q <= 1'b0;
    end
    else
    begin
      ev_meta_q <= event_in;
      ev_sync_q <= ev_meta_q;
    end
  end

  // polarity applied before edge detection
  assign ev_level = ev_sync_q ^ ev_routing_q[EV_POL_BIT];

  // previous raw level, so enable or polarity writes make no false edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ev_last_q <= 1'b0;
    else
      ev_last_q <= ev_sync_q;
  end

  // old sample seen through the current polarity
  assign ev_prev_level = ev_last_q ^ ev_routing_q[EV_POL_BIT];

  // edges only count while input is enabled
  assign ev_rise = ev_routing_q[EV_IN_EN_BIT] & ev_level & ~ev_prev_level;
  assign ev_fall = ev_routing_q[EV_IN_EN_BIT] & ~ev_level & ev_prev_level;

  // ************************************************************
  // event action decode
  // ************************************************************

  ev_cmd_t cmd_d;
  ev_act_t act;

  assign act = ev_act_t'(ev_routing_q[EV_ACT_LSB +: EV_ACT_W]);

  // rising edge starts a period, falling edge ends the pulse
  always_comb
  begin
    cmd_d = '0;
    case (act)
      ACT_RETRIGGER: cmd_d.retrigger = ev_rise;
      ACT_COUNT: cmd_d.count = ev_rise;
      ACT_START: cmd_d.start = ev_rise;
      ACT_PERIOD_REG0:
      begin
        cmd_d.period_cap = {1'b0, ev_rise};
        cmd_d.width_cap = {ev_fall, 1'b0};
      end
      ACT_PERIOD_REG1:
      begin
        cmd_d.period_cap = {ev_rise, 1'b0};
        cmd_d.width_cap = {1'b0, ev_fall};
      end
      default: cmd_d = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ev_cmd <= '0;
    else
      ev_cmd <= cmd_d;
  end

  // ************************************************************
  // read data
  // ************************************************************

  // unmapped addresses read zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (address == reg_addr(IDX_EV_ROUTING))
      rdata_d[15:0] = ev_routing_q;
    else if (address == reg_addr(IDX_IEN_CLEAR))
      rdata_d[7:0] = ien_q;
    else if (address == reg_addr(IDX_IEN_SET))
      rdata_d[7:0] = ien_q;
    else if (address == reg_addr(IDX_IRQ_FLAGS))
      rdata_d[7:0] = flags_q;
    else if (address == reg_addr(IDX_EV_STATUS))
    begin
      rdata_d[STAT_EV_LEVEL_BIT] = ev_level;
      rdata_d[STAT_TIMER_ON_BIT] = timer_enabled;
      rdata_d[STAT_GUARD_BIT] = write_guard;
    end
  end

  // sampled in the wait cycle, valid while waitrequest is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else if (read && wait_q)
      rdata_q <= rdata_d;
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;

endmodule

// >>> timer_event_ctrl_asserts.sv
`timescale 1ns/1ps
module timer_event_ctrl_chk
  import timer_event_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // core and event side
  input wire core_evt_t core_evt,
  input wire ev_cmd_t ev_cmd,
  input wire logic [1:0] channel_event_out,
  input wire logic wrap_event_out,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // helper terms
  wire logic req = read | write;
  wire logic any_evt = |core_evt;
  wire logic mapped = address inside {8'h28, 8'h30, 8'h34, 8'h38, 8'h3C};
  // ****************
  // checks
  // ****************
  a_chan_evt_src: assert property ((channel_event_out & ~$past(core_evt.ch_hit)) == 2'b00)
    else $error("channel event without hit");
  a_wrap_evt_src: assert property (wrap_event_out |-> $past(core_evt.wrap))
    else $error("wrap event without wrap");
  a_irq_cause: assert property ($rose(irq) |-> $past(any_evt, 2) || $past(write, 2))
    else $error("irq rose without cause");
  a_cmd_pulse: assert property (ev_cmd.retrigger |=> !ev_cmd.retrigger)
    else $error("retrigger longer than one cycle");
  a_cap_split: assert property ($onehot0({|ev_cmd.period_cap, |ev_cmd.width_cap,
    ev_cmd.retrigger, ev_cmd.count, ev_cmd.start}))
    else $error("two event commands at once");
  a_answer_time: assert property ($rose(req) |=> !waitrequest)
    else $error("no answer one cycle after request");
  a_wait_once: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  a_idle_wait: assert property (!req |=> waitrequest)
    else $error("answer without request");
  a_unmapped_zero: assert property (!waitrequest && read && !mapped |-> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (waitrequest |-> $stable(readdata))
    else $error("read data moved outside answer");
  // main scenarios
  c_read: cover property (read && !waitrequest);
  c_irq: cover property ($rose(irq));
  c_chan: cover property (channel_event_out[0]);
  c_retrig: cover property (ev_cmd.retrigger);
endmodule
bind timer_event_ctrl timer_event_ctrl_chk chk_inst (.clk, .rstn, .address, .read, .write,
  .readdata, .waitrequest, .core_evt, .ev_cmd, .channel_event_out, .wrap_event_out, .irq);

// >>> event_system_model.sv
`timescale 1ns/1ps
module event_system_model
  import timer_event_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // source level from the bench
  input wire logic src_level,
  // timer side
  input wire logic [1:0] channel_event_out,
  input wire logic wrap_event_out,
  output logic event_in,
  // received event counts
  output logic [7:0] ch0_cnt,
  output logic [7:0] ch1_cnt,
  output logic [7:0] wrap_cnt
);
  // event source is a plain level toward the timer
  assign event_in = src_level;
  // count every event the timer routes out
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ch0_cnt <= 8'h00;
      ch1_cnt <= 8'h00;
      wrap_cnt <= 8'h00;
    end
    else
    begin
      ch0_cnt <= ch0_cnt + 8'(channel_event_out[0]);
      ch1_cnt <= ch1_cnt + 8'(channel_event_out[1]);
      wrap_cnt <= wrap_cnt + 8'(wrap_event_out);
    end
  end
endmodule

// >>> tb_timer_event_ctrl.sv
`timescale 1ns/1ps
module tb_timer_event_ctrl;
  import timer_event_pkg::*;
  typedef struct packed {logic [7:0] wa; logic [15:0] wd; logic [7:0] ra; logic [15:0] ex;} row_t;
  logic clk, rstn, read, write, timer_enabled, write_guard, src, event_in, clr;
  logic waitrequest, wrap_event_out, irq;
  logic [7:0] address, ch0_cnt, ch1_cnt, wrap_cnt;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  logic [1:0] channel_event_out;
  logic [6:0] obs, mid;
  core_evt_t core_evt;
  ev_cmd_t ev_cmd;
  int num_errors, compares, cyc, i;
  // write address, write data, read address, expected read
  row_t rows [7] = '{{8'h28, 16'hFFFF, 8'h28, 16'h3137}, {8'h34, 16'h003B, 8'h30, 16'h003B},
    {8'h30, 16'h0000, 8'h34, 16'h003B}, {8'h30, 16'h0011, 8'h34, 16'h002A},
    {8'h30, 16'h002A, 8'h30, 16'h0000}, {8'h40, 16'h1234, 8'h40, 16'h0000},
    {8'h28, 16'h0000, 8'h28, 16'h0000}};
  // commands seen for each action code
  logic [6:0] act_exp [8] = '{7'h00, 7'h40, 7'h20, 7'h10, 7'h00, 7'h06, 7'h09, 7'h00};
  timer_event_ctrl timer_event_ctrl_inst (.clk, .rstn, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .timer_enabled, .write_guard, .core_evt, .ev_cmd,
    .event_in, .channel_event_out, .wrap_event_out, .irq);
  event_system_model event_system_model_inst (.clk, .rstn, .src_level(src), .channel_event_out,
    .wrap_event_out, .event_in, .ch0_cnt, .ch1_cnt, .wrap_cnt);
  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // cycle limit and command collector
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    obs <= clr ? 7'h00 : obs | ev_cmd;
    if (cyc == 5000)
    begin
      num_errors++;
      test_done;
    end
  end
  // ****************
  // tasks
  // ****************
  task test_done;
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] g, input string n);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // one avalon access held until waitrequest is low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0000_0000);
    chk(e, q, n);
  endtask
  task pulse(input logic [4:0] e);
    @(posedge clk) core_evt <= e;
    @(posedge clk) core_evt <= '0;
  endtask
  task ck_irq(input logic e);
    @(posedge clk);
    @(negedge clk);
    chk(32'(e), 32'(irq), "irq");
  endtask
  // one pin pulse, commands before the fall kept in mid
  task evp;
    repeat (6) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    src <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk) mid = obs;
    @(posedge clk) src <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  // main sequence
  initial
  begin
    {rstn, read, write, timer_enabled, write_guard, src, clr} = '0;
    {address, writedata, core_evt, obs, cyc, num_errors, compares} = '0;
    byteenable = 4'hF;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h28, 32'h0000_0000, "routing reset");
    rd(8'h34, 32'h0000_0000, "enable reset");
    for (i = 0; i < 7; i++)
    begin
      bus(1'b1, rows[i].wa, 32'(rows[i].wd));
      rd(rows[i].ra, 32'(rows[i].ex), "row");
    end
    timer_enabled <= 1'b1;
    bus(1'b1, 8'h28, 32'h0000_1234);
    timer_enabled <= 1'b0;
    rd(8'h28, 32'h0000_0000, "routing locked");
    write_guard <= 1'b1;
    bus(1'b1, 8'h34, 32'h0000_0001);
    rd(8'h3C, 32'h0000_0004, "status guard");
    write_guard <= 1'b0;
    rd(8'h34, 32'h0000_0000, "guarded set");
    bus(1'b1, 8'h28, 32'h0000_1100);
    pulse(5'h1C);
    bus(1'b1, 8'h28, 32'h0000_2000);
    pulse(5'h1C);
    ck_irq(1'b0);
    chk(32'h0001_0101, {8'h00, ch0_cnt, ch1_cnt, wrap_cnt}, "event counts");
    rd(8'h38, 32'h0000_0031, "flags all");
    bus(1'b1, 8'h38, 32'h0000_003B);
    bus(1'b1, 8'h34, 32'h0000_0010);
    pulse(5'h08);
    ck_irq(1'b1);
    rd(8'h38, 32'h0000_0010, "flags");
    bus(1'b1, 8'h30, 32'h0000_0010);
    ck_irq(1'b0);
    bus(1'b1, 8'h34, 32'h0000_0010);
    ck_irq(1'b1);
    bus(1'b1, 8'h38, 32'h0000_0010);
    ck_irq(1'b0);
    for (i = 0; i < 8; i++)
    begin
      bus(1'b1, 8'h28, 32'h0000_0020 | 32'(i));
      evp;
      chk(32'(act_exp[i]), 32'(obs), "action");
    end
    bus(1'b1, 8'h28, 32'h0000_0001);
    evp;
    chk(32'h0000_0000, 32'(obs), "input off");
    bus(1'b1, 8'h28, 32'h0000_0031);
    evp;
    chk(32'h0000_0040, {18'h0, mid, obs}, "inverted");
    // reset again in mid-run
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h28, 32'h0000_0000, "routing after reset");
    rd(8'h34, 32'h0000_0000, "enable after reset");
    test_done;
  end
endmodule
